// ### src/ifc_edge_det.sv
// ifc_edge_det: synchroniser and polarity-selected edge detector for the
// external interrupt pins.
// assumes pins are asynchronous to hclk; edge output is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
module ifc_edge_det #(
   parameter int N = 5
) (
   input  wire logic         hclk,
   input  wire logic         hresetn,
   input  wire logic [N-1:0] pin,
   input  wire logic [N-1:0] falling_sel,
   output logic      [N-1:0] edge_pulse
);
   logic [N-1:0] sync1_ff;
   logic [N-1:0] sync2_ff;
   logic [N-1:0] prev_ff;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sync1_ff <= '0;
         sync2_ff <= '0;
         prev_ff  <= '0;
      end
      else
      begin
         sync1_ff <= pin;
         sync2_ff <= sync1_ff;
         prev_ff  <= sync2_ff;
      end
   end

   // 1 selects falling, 0 rising, per pin
   always_comb
   begin
      for (int i = 0; i < N; i++)
      begin
         edge_pulse[i] = falling_sel[i] ? (prev_ff[i] & ~sync2_ff[i])
                                        : (~prev_ff[i] & sync2_ff[i]);
      end
   end

   chk_fall_edge_pin0 :
      assert property (@(posedge hclk) disable iff (!hresetn)
         (falling_sel[0] && $fell(sync2_ff[0])) |-> edge_pulse[0])
      else $error("falling edge on pin 0 not detected");

   chk_rise_edge_pin0 :
      assert property (@(posedge hclk) disable iff (!hresetn)
         (!falling_sel[0] && edge_pulse[0]) |-> $rose(sync2_ff[0]))
      else $error("pin 0 pulse without a rising edge");
endmodule
`default_nettype wire

// ### src/ifc_pkg.sv
// ifc_pkg: types shared by the interrupt flag and edge control block.
// assumes nothing of its surroundings.
package ifc_pkg;
   typedef logic [15:0] ifc_word_t;
   typedef enum logic [2:0]
   {
      IFC_SEL_NONE,
      IFC_SEL_CTRL2,
      IFC_SEL_FLAGS0,
      IFC_SEL_FLAGS1,
      IFC_SEL_FLAGS2,
      IFC_SEL_STAT,
      IFC_SEL_MASK
   } ifc_sel_e;
endpackage

// ### src/ifc_regs.svh
// ifc_regs.svh: offsets, field positions, masks and reset values of the
// interrupt flag and edge control block.
// assumes word-aligned AHB-Lite accesses with byte addresses in haddr.
`ifndef IFC_REGS_SVH
`define IFC_REGS_SVH

`define IFC_ADDR_W          8
`define IFC_OFF_CTRL2       8'h00
`define IFC_OFF_FLAGS0      8'h04
`define IFC_OFF_FLAGS1      8'h08
`define IFC_OFF_FLAGS2      8'h0C
`define IFC_OFF_STAT        8'h10
`define IFC_OFF_MASK        8'h14

`define IFC_CTRL2_ALT_BIT   15
`define IFC_CTRL2_TDIS_BIT  14
`define IFC_CTRL2_EP_HI     4
`define IFC_CTRL2_WMASK     16'h801F
`define IFC_CTRL2_RSV_MASK  16'h3FE0

`define IFC_FLAGS0_MASK     16'h7FFF
`define IFC_FLAGS1_MASK     16'hFFFB
`define IFC_FLAGS2_MASK     16'hDFFF

`define IFC_EXT0_BIT        0
`define IFC_EXT1_BIT        4
`define IFC_EXT2_BIT        13

`define IFC_RST16           16'h0000
`define IFC_RST32           32'h0000_0000
`define IFC_EXT_N           5
`define IFC_STAT_W          4
`define IFC_STAT_RST        4'h0
`define IFC_STAT_F0         0
`define IFC_STAT_F1         1
`define IFC_STAT_F2         2
`define IFC_STAT_EXTHI      3

`endif

// ### src/ifc_top.sv
// ifc_top: second interrupt control register and the first three interrupt
// flag registers, reached over AHB-Lite, with a sticky event status.
// assumes single word transfers, one slave, peripheral requests as pulses.
`timescale 1ns/1ps
`default_nettype none
`include "ifc_regs.svh"
module ifc_top (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic [15:0] flags0_req,
   input  wire logic [15:0] flags1_req,
   input  wire logic [15:0] flags2_req,
   input  wire logic [4:0]  ext_irq_pin,
   input  wire logic        timed_irq_disable_active,
   output logic             alt_vector_table_sel,
   output logic [4:0]       ext_irq_falling_sel,
   output logic [15:0]      flags0,
   output logic [15:0]      flags1,
   output logic [15:0]      flags2,
   output logic [1:0]       ext_irq_hi_edge,
   output logic             irq
);
   logic                     alt_ff;
   logic [4:0]               ep_ff;
   ifc_pkg::ifc_word_t       flags0_ff;
   ifc_pkg::ifc_word_t       flags1_ff;
   ifc_pkg::ifc_word_t       flags2_ff;
   logic [`IFC_STAT_W-1:0]   stat_ff;
   logic [`IFC_STAT_W-1:0]   mask_ff;
   logic                     irq_ff;
   logic [1:0]               ext_hi_ff;
   logic [31:0]              hrdata_ff;
   logic                     hreadyout_ff;
   logic                     wr_pend_ff;
   ifc_pkg::ifc_sel_e        wr_sel_ff;

   ifc_pkg::ifc_word_t       nxt_flags0;
   ifc_pkg::ifc_word_t       nxt_flags1;
   ifc_pkg::ifc_word_t       nxt_flags2;
   logic                     nxt_alt;
   logic [4:0]               nxt_ep;
   logic [`IFC_STAT_W-1:0]   nxt_stat;
   logic [`IFC_STAT_W-1:0]   nxt_mask;
   logic [`IFC_STAT_W-1:0]   stat_set;
   ifc_pkg::ifc_word_t       set0;
   ifc_pkg::ifc_word_t       set1;
   ifc_pkg::ifc_word_t       set2;
   logic [4:0]               ext_edge;
   logic                     addr_ok;
   ifc_pkg::ifc_sel_e        addr_sel;
   logic                     rd_take;
   logic [31:0]              rd_val;
   logic                     wr_ctrl;
   logic                     wr_f0;
   logic                     wr_f1;
   logic                     wr_f2;
   logic                     wr_mask;

   function automatic ifc_pkg::ifc_sel_e decode(input logic [`IFC_ADDR_W-1:0] a);
      ifc_pkg::ifc_sel_e s;
      s = ifc_pkg::IFC_SEL_NONE;
      case (a)
         `IFC_OFF_CTRL2:  s = ifc_pkg::IFC_SEL_CTRL2;
         `IFC_OFF_FLAGS0: s = ifc_pkg::IFC_SEL_FLAGS0;
         `IFC_OFF_FLAGS1: s = ifc_pkg::IFC_SEL_FLAGS1;
         `IFC_OFF_FLAGS2: s = ifc_pkg::IFC_SEL_FLAGS2;
         `IFC_OFF_STAT:   s = ifc_pkg::IFC_SEL_STAT;
         `IFC_OFF_MASK:   s = ifc_pkg::IFC_SEL_MASK;
         default:         s = ifc_pkg::IFC_SEL_NONE;
      endcase
      return s;
   endfunction

   // hardware set wins over a software write of zero in the same cycle
   function automatic ifc_pkg::ifc_word_t merge(input ifc_pkg::ifc_word_t cur,
                                                input logic               wr,
                                                input ifc_pkg::ifc_word_t wdat,
                                                input ifc_pkg::ifc_word_t set,
                                                input ifc_pkg::ifc_word_t impl);
      ifc_pkg::ifc_word_t v;
      v = wr ? wdat : cur;
      return (v | set) & impl;
   endfunction

   ifc_edge_det #(
      .N (`IFC_EXT_N)
   ) u_edge (
      .hclk        (hclk),
      .hresetn     (hresetn),
      .pin         (ext_irq_pin),
      .falling_sel (ep_ff),
      .edge_pulse  (ext_edge)
   );

   // address phase
   assign addr_ok  = hsel & htrans[1] & hready;
   assign addr_sel = decode(haddr[`IFC_ADDR_W-1:0]);
   assign rd_take  = addr_ok & ~hwrite;

   // data phase write strobes
   assign wr_ctrl = wr_pend_ff & (wr_sel_ff == ifc_pkg::IFC_SEL_CTRL2);
   assign wr_f0   = wr_pend_ff & (wr_sel_ff == ifc_pkg::IFC_SEL_FLAGS0);
   assign wr_f1   = wr_pend_ff & (wr_sel_ff == ifc_pkg::IFC_SEL_FLAGS1);
   assign wr_f2   = wr_pend_ff & (wr_sel_ff == ifc_pkg::IFC_SEL_FLAGS2);
   assign wr_mask = wr_pend_ff & (wr_sel_ff == ifc_pkg::IFC_SEL_MASK);

   // request routing; external pins 0..2 land here, 3 and 4 go out as pulses
   always_comb
   begin
      set0 = flags0_req;
      set1 = flags1_req;
      set2 = flags2_req;
      set0[`IFC_EXT0_BIT] = flags0_req[`IFC_EXT0_BIT] | ext_edge[0];
      set1[`IFC_EXT1_BIT] = flags1_req[`IFC_EXT1_BIT] | ext_edge[1];
      set1[`IFC_EXT2_BIT] = flags1_req[`IFC_EXT2_BIT] | ext_edge[2];
   end

   assign nxt_flags0 = merge(flags0_ff, wr_f0, hwdata[15:0], set0,
                             `IFC_FLAGS0_MASK);
   assign nxt_flags1 = merge(flags1_ff, wr_f1, hwdata[15:0], set1,
                             `IFC_FLAGS1_MASK);
   assign nxt_flags2 = merge(flags2_ff, wr_f2, hwdata[15:0], set2,
                             `IFC_FLAGS2_MASK);
   assign nxt_alt    = wr_ctrl ? hwdata[`IFC_CTRL2_ALT_BIT] : alt_ff;
   assign nxt_ep     = wr_ctrl ? hwdata[`IFC_CTRL2_EP_HI:0] : ep_ff;
   assign nxt_mask   = wr_mask ? hwdata[`IFC_STAT_W-1:0] : mask_ff;

   // sticky events: any hardware-raised flag in each register, pins 3/4
   always_comb
   begin
      stat_set = `IFC_STAT_RST;
      stat_set[`IFC_STAT_F0]    = |(set0 & `IFC_FLAGS0_MASK);
      stat_set[`IFC_STAT_F1]    = |(set1 & `IFC_FLAGS1_MASK);
      stat_set[`IFC_STAT_F2]    = |(set2 & `IFC_FLAGS2_MASK);
      stat_set[`IFC_STAT_EXTHI] = |ext_edge[4:3];
   end

   // a read clears status, but an event in that same cycle survives
   assign nxt_stat = ((rd_take && addr_sel == ifc_pkg::IFC_SEL_STAT) ?
                      `IFC_STAT_RST : stat_ff) | stat_set;

   // read data taken from next-state values so a write in the preceding
   // data phase is already visible without a wait state
   always_comb
   begin
      rd_val = `IFC_RST32;
      case (addr_sel)
         ifc_pkg::IFC_SEL_CTRL2:
         begin
            rd_val[`IFC_CTRL2_ALT_BIT]  = nxt_alt;
            rd_val[`IFC_CTRL2_TDIS_BIT] = timed_irq_disable_active;
            rd_val[`IFC_CTRL2_EP_HI:0]  = nxt_ep;
         end
         ifc_pkg::IFC_SEL_FLAGS0: rd_val[15:0] = nxt_flags0;
         ifc_pkg::IFC_SEL_FLAGS1: rd_val[15:0] = nxt_flags1;
         ifc_pkg::IFC_SEL_FLAGS2: rd_val[15:0] = nxt_flags2;
         ifc_pkg::IFC_SEL_STAT:   rd_val[`IFC_STAT_W-1:0] = stat_ff | stat_set;
         ifc_pkg::IFC_SEL_MASK:   rd_val[`IFC_STAT_W-1:0] = nxt_mask;
         default:                 rd_val = `IFC_RST32;
      endcase
   end

   // bus front end; zero wait state, always OKAY
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_ff   <= 1'b0;
         wr_sel_ff    <= ifc_pkg::IFC_SEL_NONE;
         hrdata_ff    <= `IFC_RST32;
         hreadyout_ff <= 1'b1;
      end
      else
      begin
         wr_pend_ff   <= addr_ok & hwrite;
         wr_sel_ff    <= addr_ok ? addr_sel : ifc_pkg::IFC_SEL_NONE;
         hrdata_ff    <= rd_take ? rd_val : `IFC_RST32;
         hreadyout_ff <= 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         alt_ff  <= 1'b0;
         ep_ff   <= 5'h0;
      end
      else
      begin
         alt_ff  <= nxt_alt;
         ep_ff   <= nxt_ep;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         flags0_ff <= `IFC_RST16;
         flags1_ff <= `IFC_RST16;
         flags2_ff <= `IFC_RST16;
      end
      else
      begin
         flags0_ff <= nxt_flags0;
         flags1_ff <= nxt_flags1;
         flags2_ff <= nxt_flags2;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         stat_ff   <= `IFC_STAT_RST;
         mask_ff   <= `IFC_STAT_RST;
         irq_ff    <= 1'b0;
         ext_hi_ff <= 2'h0;
      end
      else
      begin
         stat_ff   <= nxt_stat;
         mask_ff   <= nxt_mask;
         irq_ff    <= |(nxt_stat & nxt_mask);
         ext_hi_ff <= ext_edge[4:3];
      end
   end

   assign hrdata               = hrdata_ff;
   assign hreadyout            = hreadyout_ff;
   assign hresp                = 1'b0;
   assign alt_vector_table_sel = alt_ff;
   assign ext_irq_falling_sel  = ep_ff;
   assign flags0               = flags0_ff;
   assign flags1               = flags1_ff;
   assign flags2               = flags2_ff;
   assign ext_irq_hi_edge      = ext_hi_ff;
   assign irq                  = irq_ff;

   chk_alt_table_write :
      assert property (@(posedge hclk) disable iff (!hresetn)
         wr_ctrl |=> alt_vector_table_sel == $past(hwdata[`IFC_CTRL2_ALT_BIT]))
      else $error("vector table select did not take written value");

   chk_tdis_readback :
      assert property (@(posedge hclk) disable iff (!hresetn)
         (rd_take && addr_sel == ifc_pkg::IFC_SEL_CTRL2)
         |=> hrdata[`IFC_CTRL2_TDIS_BIT] == $past(timed_irq_disable_active))
      else $error("timed disable status misread");

   chk_polarity_write :
      assert property (@(posedge hclk) disable iff (!hresetn)
         wr_ctrl |=> ext_irq_falling_sel == $past(hwdata[`IFC_CTRL2_EP_HI:0]))
      else $error("edge polarity select not written");

   chk_reserved_zero :
      assert property (@(posedge hclk) disable iff (!hresetn)
         (hrdata[31:16] == 16'h0000) && ((hrdata[15:0] & `IFC_CTRL2_RSV_MASK) == 16'h0000
          || !$past(rd_take && addr_sel == ifc_pkg::IFC_SEL_CTRL2))
         && (flags0 & ~`IFC_FLAGS0_MASK) == 16'h0000
         && (flags1 & ~`IFC_FLAGS1_MASK) == 16'h0000
         && (flags2 & ~`IFC_FLAGS2_MASK) == 16'h0000)
      else $error("unimplemented bit reads nonzero");

   chk_reset_zero :
      assert property (@(posedge hclk)
         $rose(hresetn) |-> (flags0 == 16'h0000 && flags1 == 16'h0000
                             && flags2 == 16'h0000 && !alt_vector_table_sel
                             && ext_irq_falling_sel == 5'h00 && !irq))
      else $error("state not zero after reset");

   chk_flag_sw_write :
      assert property (@(posedge hclk) disable iff (!hresetn)
         (wr_f0 && flags0_req == 16'h0000 && !ext_edge[0])
         |=> flags0 == ($past(hwdata[15:0]) & `IFC_FLAGS0_MASK))
      else $error("flag register 0 write lost");

   chk_set_beats_clear :
      assert property (@(posedge hclk) disable iff (!hresetn)
         (wr_f1 && flags1_req[0]) |=> flags1[0])
      else $error("hardware set lost against software clear");

   chk_map_reg0_top :
      assert property (@(posedge hclk) disable iff (!hresetn)
         flags0_req[14] |=> flags0[14])
      else $error("DMA channel 1 request not flagged");

   chk_map_reg1_unused :
      assert property (@(posedge hclk) disable iff (!hresetn)
         flags1_req[2] && !$past(flags1[2]) |=> !flags1[2])
      else $error("unused bit 2 of flag register 1 set");

   chk_map_reg2_timer6 :
      assert property (@(posedge hclk) disable iff (!hresetn)
         flags2_req[15] |=> flags2[15])
      else $error("timer six request not flagged");

   chk_ext_pin_flag :
      assert property (@(posedge hclk) disable iff (!hresetn)
         ext_edge[2] |=> flags1[`IFC_EXT2_BIT])
      else $error("external pin 2 edge not flagged");

   chk_can_rx_flag :
      assert property (@(posedge hclk) disable iff (!hresetn)
         flags2_req[2] |=> flags2[2] ##0 stat_ff[`IFC_STAT_F2])
      else $error("CAN receive request not flagged");

   chk_flag_sticky :
      assert property (@(posedge hclk) disable iff (!hresetn)
         !wr_f0 |=> (flags0 & $past(flags0)) == $past(flags0))
      else $error("flag register 0 bit dropped without a write");

   chk_stat_read_clear :
      assert property (@(posedge hclk) disable iff (!hresetn)
         (rd_take && addr_sel == ifc_pkg::IFC_SEL_STAT && stat_set == `IFC_STAT_RST)
         |=> stat_ff == `IFC_STAT_RST)
      else $error("status not cleared by its read");

   chk_irq_level :
      assert property (@(posedge hclk) disable iff (!hresetn)
         ##1 irq == |(stat_ff & mask_ff))
      else $error("interrupt output disagrees with status and mask");
endmodule
`default_nettype wire

// ### verification/ifc_src_model.sv
// ifc_src_model: stands in for the peripheral request sources, the external
// pins and the cpu's timed-disable level.
// assumes the bench drives its command inputs by non-blocking assignment.
`timescale 1ns/1ps
`default_nettype none
module ifc_src_model (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic [47:0] fire,
   input  wire logic [4:0]  pin_cmd,
   input  wire logic        tdis_cmd,
   output logic      [15:0] req0,
   output logic      [15:0] req1,
   output logic      [15:0] req2,
   output logic      [4:0]  pin,
   output logic             tdis
);
   // requests are one-cycle strobes, as a peripheral would give them
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         {req2, req1, req0} <= 48'h0000_0000_0000;
      else
         {req2, req1, req0} <= fire;
   // pins follow the command one clock later, like any synchronous source
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         pin <= 5'h00;
      else
         pin <= pin_cmd;
   assign tdis = tdis_cmd;
endmodule
`default_nettype wire

// ### verification/testbench.sv
// testbench: register, flag, interrupt and edge tests of ifc_top.
// assumes a zero-wait-state slave and the source model on the far side.
`timescale 1ns/1ps
`default_nettype none
`include "ifc_regs.svh"
module testbench;
   localparam logic [31:0] A_CTRL = 32'(`IFC_OFF_CTRL2);
   localparam logic [31:0] A_STAT = 32'(`IFC_OFF_STAT);
   localparam logic [31:0] A_MASK = 32'(`IFC_OFF_MASK);
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, alt_sel, tdis, tdis_cmd;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans, hi_edge;
   logic [2:0]  hsize;
   logic [4:0]  pin, pin_cmd, fall_sel;
   logic [15:0] req0, req1, req2, flags0, flags1, flags2;
   logic [47:0] fire;
   logic [4:0]  obs;
   logic [15:0] msk [3] = '{16'h7FFF, 16'hFFFB, 16'hDFFF};
   int          error_cnt = 0;
   int          checks_done = 0;
   assign obs = {hi_edge, flags1[13], flags1[4], flags0[0]};
   ifc_src_model src (.hclk(hclk), .hresetn(hresetn), .fire(fire), .pin_cmd(pin_cmd),
      .tdis_cmd(tdis_cmd), .req0(req0), .req1(req1), .req2(req2), .pin(pin), .tdis(tdis));
   ifc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .flags0_req(req0), .flags1_req(req1),
      .flags2_req(req2), .ext_irq_pin(pin), .timed_irq_disable_active(tdis),
      .alt_vector_table_sel(alt_sel), .ext_irq_falling_sel(fall_sel), .flags0(flags0),
      .flags1(flags1), .flags2(flags2), .ext_irq_hi_edge(hi_edge), .irq(irq));
   always #12.5 hclk = ~hclk;
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // a slave that never answers must not hang the run
   task automatic wait_ready();
      int n;
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1)
      begin
         n++;
         if (n > 50)
         begin
            error_cnt++;
            final_report();
         end
         @(posedge hclk);
      end
   endtask
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= w;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_ready();
      q = hrdata;
      chk_word("hresp", 32'h0000_0000, {31'h0, hresp});
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] q;
      ahb(1'b1, a, d, q);
   endtask
   task automatic rd_chk(input string nm, input logic [31:0] a, input logic [31:0] e);
      logic [31:0] q;
      ahb(1'b0, a, 32'h0000_0000, q);
      chk_word(nm, e, q);
   endtask
   task automatic pulse(input int r, input logic [15:0] w);
      @(posedge hclk);
      fire <= 48'(w) << (16 * r);
      @(posedge hclk);
      fire <= 48'h0000_0000_0000;
   endtask
   task automatic clr_flags();
      wr(32'(`IFC_OFF_FLAGS0), 32'h0000_0000);
      wr(32'(`IFC_OFF_FLAGS1), 32'h0000_0000);
   endtask
   // window is well past the synchroniser latency; flags are sticky anyway
   task automatic drive_pin(input int p, input logic lvl, input logic exp);
      logic seen;
      @(posedge hclk);
      pin_cmd[p] <= lvl;
      seen = 1'b0;
      repeat (10)
      begin
         @(posedge hclk);
         #1 seen = seen | obs[p];
      end
      chk_word("edge flag", {31'h0, exp}, {31'h0, seen});
   endtask
   task automatic edge_case(input int p, input logic fall);
      wr(A_CTRL, 32'(fall) << p);
      // the select register loads at the edge that ends the write
      @(posedge hclk);
      chk_word("fall sel", 32'(fall) << p, {27'h0, fall_sel});
      clr_flags();
      drive_pin(p, 1'b1, !fall);
      clr_flags();
      drive_pin(p, 1'b0, fall);
   endtask
   initial
   begin
      hclk = 1'b0;
      hresetn = 1'b0;
      {hsel, hwrite, tdis_cmd} = 3'h0;
      haddr = 32'h0000_0000;
      hwdata = 32'h0000_0000;
      htrans = 2'b00;
      hsize = 3'b010;
      pin_cmd = 5'h00;
      fire = 48'h0000_0000_0000;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      for (int i = 0; i < 7; i++)
         rd_chk("reset value", 32'(4 * i), 32'h0000_0000);
      chk_word("irq reset", 32'h0000_0000, {31'h0, irq});
      $display("test reset done");
      wr(A_CTRL, 32'hFFFF_FFFF);
      rd_chk("ctrl2", A_CTRL, 32'h0000_801F);
      chk_word("alt sel", 32'h0000_0001, {31'h0, alt_sel});
      @(posedge hclk);
      tdis_cmd <= 1'b1;
      rd_chk("ctrl2 tdis", A_CTRL, 32'h0000_C01F);
      wr(A_CTRL, 32'h0000_0000);
      rd_chk("ctrl2 ro", A_CTRL, 32'h0000_4000);
      chk_word("alt sel", 32'h0000_0000, {31'h0, alt_sel});
      tdis_cmd <= 1'b0;
      $display("test control done");
      for (int r = 0; r < 3; r++)
      begin
         wr(32'(4 + 4 * r), 32'hFFFF_FFFF);
         rd_chk("flag rw", 32'(4 + 4 * r), {16'h0, msk[r]});
         wr(32'(4 + 4 * r), 32'h0000_0000);
         for (int b = 0; b < 16; b++)
         begin
            pulse(r, 16'h0001 << b);
            rd_chk("flag bit", 32'(4 + 4 * r), {16'h0, msk[r] & 16'h0001 << b});
            chk_word("flag out", {16'h0, msk[r] & (16'h0001 << b)},
                     {16'h0, (r == 0) ? flags0 : (r == 1) ? flags1 : flags2});
            wr(32'(4 + 4 * r), 32'h0000_0000);
         end
      end
      $display("test flags done");
      rd_chk("status", A_STAT, 32'h0000_0007);
      wr(A_MASK, 32'h0000_0002);
      pulse(0, 16'h0020);
      rd_chk("mask", A_MASK, 32'h0000_0002);
      chk_word("irq masked", 32'h0000_0000, {31'h0, irq});
      pulse(1, 16'h0008);
      rd_chk("mask", A_MASK, 32'h0000_0002);
      chk_word("irq raised", 32'h0000_0001, {31'h0, irq});
      rd_chk("status", A_STAT, 32'h0000_0003);
      rd_chk("status clr", A_STAT, 32'h0000_0000);
      chk_word("irq cleared", 32'h0000_0000, {31'h0, irq});
      wr(A_MASK, 32'h0000_0000);
      clr_flags();
      // request lands on the very edge that commits a write of zero
      fork
         wr(32'(`IFC_OFF_FLAGS1), 32'h0000_0000);
         pulse(1, 16'h0001);
      join
      rd_chk("set wins", 32'(`IFC_OFF_FLAGS1), 32'h0000_0001);
      $display("test interrupt done");
      for (int p = 0; p < 5; p++)
      begin
         edge_case(p, 1'b0);
         edge_case(p, 1'b1);
      end
      $display("test edges done");
      final_report();
   end
endmodule
`default_nettype wire
